/* File: dv/pll_synth_assertions.sv */
// timing checks on the synthesizer program latches
`default_nettype none
module pll_synth_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic latch_strobe,
  input wire logic [15:0] integer_value,
  input wire logic [11:0] denominator_value,
  input wire logic [11:0] phase_word,
  input wire logic [9:0] reference_divider,
  input wire logic [3:0] pump_current,
  input wire logic phase_adjust_bit,
  input wire logic [1:0] clock_divider_mode,
  input wire logic [11:0] clock_divider_value,
  input wire logic [1:0] lock_pin_mode,
  input wire logic commit_pulse,
  input wire logic phase_resync_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  pulse_single_a: assert property (commit_pulse |=> !commit_pulse)
    else $error("commit pulse longer than one cycle");
  resync_needs_commit_a: assert property (phase_resync_pulse |-> commit_pulse)
    else $error("resync without commit");
  resync_rule_a: assert property (commit_pulse |->
    phase_resync_pulse == (!phase_adjust_bit && clock_divider_mode == 2'h2))
    else $error("resync pulse disagrees with adjust bit and divider mode");
  den_buffered_a: assert property ($changed({denominator_value, phase_word})
    |-> commit_pulse) else $error("denominator or phase moved without commit");
  ref_buffered_a: assert property ($changed({reference_divider, pump_current})
    |-> commit_pulse) else $error("reference divider or pump moved without commit");
  int_after_strobe_a: assert property ($changed(integer_value) |->
    $past(latch_strobe, 3) || $past(latch_strobe, 4) || $past(latch_strobe, 5))
    else $error("integer value moved without strobe");
  clkdiv_after_strobe_a: assert property ($changed(clock_divider_value) |->
    $past(latch_strobe, 3) || $past(latch_strobe, 4) || $past(latch_strobe, 5))
    else $error("clock divider value moved without strobe");
  lock_after_strobe_a: assert property ($changed(lock_pin_mode) |->
    $past(latch_strobe, 3) || $past(latch_strobe, 4) || $past(latch_strobe, 5))
    else $error("lock pin mode moved without strobe");
endmodule // pll_synth_checker
bind pll_synth_program_registers pll_synth_checker checker_i (.clk, .arst_n, .latch_strobe,
  .integer_value, .denominator_value, .phase_word, .reference_divider, .pump_current,
  .phase_adjust_bit, .clock_divider_mode, .clock_divider_value, .lock_pin_mode,
  .commit_pulse, .phase_resync_pulse);
`default_nettype wire

/* File: dv/serial_host_model.sv */
// host model that shifts program words into the three serial pins
`default_nettype none
module serial_host_model (
  input wire logic clk,
  output logic serial_clk,
  output logic serial_data,
  output logic latch_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk = 1'h0;
    serial_data = 1'h0;
    latch_strobe = 1'h0;
  end
  // each level is held three cycles so the pin synchronisers cannot miss it
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      @(negedge clk);
      serial_clk = 1'h0;
      serial_data = w[i];
      repeat (3) @(negedge clk);
      serial_clk = 1'h1;
      repeat (2) @(negedge clk);
    end
    @(negedge clk);
    serial_clk = 1'h0;
    // released data line shows the inverse, not a stale copy of bit 0
    serial_data = ~w[0];
    repeat (3) @(negedge clk);
    latch_strobe = 1'h1;
    repeat (3) @(negedge clk);
    latch_strobe = 1'h0;
    repeat (4) @(negedge clk);
  endtask
endmodule // serial_host_model
`default_nettype wire

/* File: dv/test_pll_synth_program_registers.sv */
// self-checking bench for the synthesizer program latches
`default_nettype none
module test_pll_synth_program_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  wire serial_clk, serial_data, latch_strobe;
  wire [15:0] integer_value;
  wire [11:0] numerator_value, denominator_value, phase_word, clock_divider_value;
  wire prescaler_select, phase_adjust_bit, reference_doubler, reference_halving;
  wire [1:0] noise_mode, clock_divider_mode, lock_pin_mode;
  wire [2:0] output_mux_select;
  wire [9:0] reference_divider;
  wire [3:0] pump_current;
  wire [5:0] control_flags;
  wire antibacklash_width, charge_cancel, cycle_slip_reduction, commit_pulse;
  wire phase_resync_pulse;
  wire [28:0] reserved_pattern;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int commits = 0;
  int resyncs = 0;
  pll_synth_program_registers pll_synth_program_registers_i (.clk, .arst_n, .serial_clk,
    .serial_data, .latch_strobe, .integer_value, .numerator_value, .denominator_value,
    .phase_word, .prescaler_select, .phase_adjust_bit, .noise_mode, .output_mux_select,
    .reference_doubler, .reference_halving, .reference_divider, .pump_current,
    .control_flags, .antibacklash_width, .charge_cancel, .cycle_slip_reduction,
    .clock_divider_mode, .clock_divider_value, .reserved_pattern, .lock_pin_mode,
    .commit_pulse, .phase_resync_pulse);
  serial_host_model serial_host_model_i (.clk, .serial_clk, .serial_data, .latch_strobe);
  always #4 clk = ~clk;
  // pulses last one cycle, so they are counted rather than polled
  always @(posedge clk) begin
    cycles++;
    if (commit_pulse === 1'h1) commits++;
    if (phase_resync_pulse === 1'h1) resyncs++;
    if (cycles == 8000) begin
      fails++;
      close_out;
    end
  end
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'h1;
    // phase word 1 with adjust off, 8/9 prescaler, denominator 2000
    serial_host_model_i.send({3'h0, 1'h0, 1'h1, 12'h001, 12'h7D0, 3'h1});
    check({prescaler_select, phase_adjust_bit}, 2'h2);
    check({denominator_value, phase_word}, 24'h0);
    serial_host_model_i.send({1'h0, 2'h1, 3'h5, 2'h3, 10'h3FF, 1'h0, 4'hA, 6'h2A, 3'h2});
    check({noise_mode, output_mux_select, control_flags}, {2'h1, 3'h5, 6'h2A});
    check({reference_doubler, reference_halving, reference_divider, pump_current}, 0);
    serial_host_model_i.send({9'h000, 2'h3, 2'h0, 1'h1, 1'h0, 2'h2, 12'hABC, 3'h3});
    check({antibacklash_width, charge_cancel, cycle_slip_reduction, clock_divider_mode,
      clock_divider_value}, {3'h7, 2'h2, 12'hABC});
    serial_host_model_i.send(32'h00800004);
    check(reserved_pattern, 29'h00100000);
    serial_host_model_i.send(32'h00C00005);
    check(lock_pin_mode, 2'h3);
    $display("test setup words done");
    serial_host_model_i.send(32'hFFFFFFFE);
    serial_host_model_i.send(32'hFFFFFFFF);
    check({integer_value, lock_pin_mode, clock_divider_value, reserved_pattern},
      {16'h0000, 2'h3, 12'hABC, 29'h00100000});
    check(commits, 0);
    $display("test unused selects done");
    // largest integer for 8/9 and numerator one below the denominator
    serial_host_model_i.send({1'h0, 16'hFFFF, 12'h7CF, 3'h0});
    check({integer_value, numerator_value}, {16'hFFFF, 12'h7CF});
    check({denominator_value, phase_word}, {12'h7D0, 12'h001});
    check({reference_doubler, reference_halving, reference_divider, pump_current},
      {2'h3, 10'h3FF, 4'hA});
    check({commits, resyncs}, {32'h1, 32'h1});
    // new phase and denominator must wait for the next feedback word
    serial_host_model_i.send({3'h0, 1'h1, 1'h1, 12'h002, 12'h0FA, 3'h1});
    check({prescaler_select, phase_adjust_bit}, 2'h3);
    check({denominator_value, phase_word}, {12'h7D0, 12'h001});
    serial_host_model_i.send({1'h0, 16'h004B, 12'h000, 3'h0});
    check(integer_value, 16'h004B);
    check({denominator_value, phase_word}, {12'h0FA, 12'h002});
    check({commits, resyncs}, {32'h2, 32'h1});
    $display("test commit and resync done");
    close_out;
  end
endmodule // test_pll_synth_program_registers
`default_nettype wire

/* File: pkg/pll_synth_defines.vh */
// bit positions, select codes and reset values of the synthesizer program latches
`ifndef PLL_SYNTH_DEFINES_VH
`define PLL_SYNTH_DEFINES_VH

`define WORD_WIDTH 32
`define SEL_MSB 2
`define SEL_LSB 0

`define SEL_FEEDBACK 3'h0
`define SEL_PHASE_DEN 3'h1
`define SEL_REF_PUMP 3'h2
`define SEL_CLKDIV 3'h3
`define SEL_RESERVED 3'h4
`define SEL_LOCK_PIN 3'h5

// feedback_divider_word
`define INT_MSB 30
`define INT_LSB 15
`define NUM_MSB 14
`define NUM_LSB 3

// phase_and_denominator_word
`define PH_ADJ_BIT 28
`define PRESC_BIT 27
`define PHASE_MSB 26
`define PHASE_LSB 15
`define DEN_MSB 14
`define DEN_LSB 3

// reference_and_pump_control
`define NOISE_MSB 30
`define NOISE_LSB 29
`define MUX_MSB 28
`define MUX_LSB 26
`define DOUBLER_BIT 25
`define HALVING_BIT 24
`define RDIV_MSB 23
`define RDIV_LSB 14
`define ZERO13_BIT 13
`define PUMP_MSB 12
`define PUMP_LSB 9
`define FLAGS_MSB 8
`define FLAGS_LSB 3

// clock_divider_and_pfd_options
`define ABW_BIT 22
`define CANCEL_BIT 21
`define CSR_BIT 18
`define CDM_MSB 16
`define CDM_LSB 15
`define CDV_MSB 14
`define CDV_LSB 3
`define CDM_RESYNC 2'h2

// lock_pin_configuration
`define LOCK_MSB 23
`define LOCK_LSB 22

`define LATCH_RESET 32'h00000000

`endif

/* File: src/pll_synth_program_registers.v */
// program latches of the fractional-n synthesizer with double-buffered commit on the feedback word
`default_nettype none

module pll_synth_program_registers (
  input wire clk,
  input wire arst_n,
  input wire serial_clk,
  input wire serial_data,
  input wire latch_strobe,
  output wire [15:0] integer_value,
  output wire [11:0] numerator_value,
  output wire [11:0] denominator_value,
  output wire [11:0] phase_word,
  output wire prescaler_select,
  output wire phase_adjust_bit,
  output wire [1:0] noise_mode,
  output wire [2:0] output_mux_select,
  output wire reference_doubler,
  output wire reference_halving,
  output wire [9:0] reference_divider,
  output wire [3:0] pump_current,
  output wire [5:0] control_flags,
  output wire antibacklash_width,
  output wire charge_cancel,
  output wire cycle_slip_reduction,
  output wire [1:0] clock_divider_mode,
  output wire [11:0] clock_divider_value,
  output wire [28:0] reserved_pattern,
  output wire [1:0] lock_pin_mode,
  output wire commit_pulse,
  output wire phase_resync_pulse
);

  `include "pll_synth_defines.vh"

  // ****************************************
  // helper functions
  // ****************************************
  function [2:0] select_of;
    input [31:0] word;
    begin
      select_of = word[`SEL_MSB:`SEL_LSB];
    end
  endfunction

  function sel_hit;
    input [31:0] word;
    input [2:0] code;
    begin
      sel_hit = (select_of(word) == code);
    end
  endfunction

  // ****************************************
  // serial front end
  // ****************************************
  wire word_valid;
  wire [31:0] word_data;

  // valid rises for one cycle per strobe; word_data holds until the next strobe
  serial_word_receiver u_receiver (
    .clk(clk),
    .arst_n(arst_n),
    .serial_clk(serial_clk),
    .serial_data(serial_data),
    .latch_strobe(latch_strobe),
    .word_valid(word_valid),
    .word_data(word_data)
  );

  // ****************************************
  // program latches
  // ****************************************
  reg [31:0] feedback_divider_word_reg;
  reg [31:0] phase_and_denominator_word_reg;
  reg [31:0] reference_and_pump_control_reg;
  reg [31:0] clock_divider_and_pfd_options_reg;
  reg [31:0] reserved_fixed_pattern_reg;
  reg [31:0] lock_pin_configuration_reg;

  // effective copies of the double-buffered fields
  reg [11:0] den_active_reg;
  reg [11:0] phase_active_reg;
  reg doubler_active_reg;
  reg halving_active_reg;
  reg [9:0] rdiv_active_reg;
  reg [3:0] pump_active_reg;
  reg commit_reg;
  reg resync_reg;

  // codes 110 and 111 match no latch and cannot raise a commit
  wire hit_feedback = word_valid && sel_hit(word_data, `SEL_FEEDBACK);
  // the resync decision uses settings already latched, not the word now arriving
  wire resync_enabled = !phase_and_denominator_word_reg[`PH_ADJ_BIT] &&
    (clock_divider_and_pfd_options_reg[`CDM_MSB:`CDM_LSB] == `CDM_RESYNC);

  // no power-on value is defined, so every latch clears to zero
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      feedback_divider_word_reg <= `LATCH_RESET;
      phase_and_denominator_word_reg <= `LATCH_RESET;
      reference_and_pump_control_reg <= `LATCH_RESET;
      clock_divider_and_pfd_options_reg <= `LATCH_RESET;
      reserved_fixed_pattern_reg <= `LATCH_RESET;
      lock_pin_configuration_reg <= `LATCH_RESET;
    end else if (word_valid) begin
      case (select_of(word_data))
        `SEL_FEEDBACK: begin
          feedback_divider_word_reg <= word_data;
        end
        `SEL_PHASE_DEN: begin
          phase_and_denominator_word_reg <= word_data;
        end
        `SEL_REF_PUMP: begin
          reference_and_pump_control_reg <= word_data;
        end
        `SEL_CLKDIV: begin
          clock_divider_and_pfd_options_reg <= word_data;
        end
        `SEL_RESERVED: begin
          reserved_fixed_pattern_reg <= word_data;
        end
        `SEL_LOCK_PIN: begin
          lock_pin_configuration_reg <= word_data;
        end
        default: begin
          // unused select codes are dropped
        end
      endcase
    end
  end

  // ****************************************
  // double-buffer commit and phase resync
  // ****************************************
  // the commit copies latch contents from before this cycle's word, so a
  // buffered field written earlier is applied here and not sooner
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      den_active_reg <= 12'h000;
      phase_active_reg <= 12'h000;
      doubler_active_reg <= 1'b0;
      halving_active_reg <= 1'b0;
      rdiv_active_reg <= 10'h000;
      pump_active_reg <= 4'h0;
      commit_reg <= 1'b0;
      resync_reg <= 1'b0;
    end else begin
      commit_reg <= hit_feedback;
      resync_reg <= hit_feedback && resync_enabled;
      if (hit_feedback) begin
        den_active_reg <= phase_and_denominator_word_reg[`DEN_MSB:`DEN_LSB];
        phase_active_reg <= phase_and_denominator_word_reg[`PHASE_MSB:`PHASE_LSB];
        doubler_active_reg <= reference_and_pump_control_reg[`DOUBLER_BIT];
        halving_active_reg <= reference_and_pump_control_reg[`HALVING_BIT];
        rdiv_active_reg <= reference_and_pump_control_reg[`RDIV_MSB:`RDIV_LSB];
        pump_active_reg <= reference_and_pump_control_reg[`PUMP_MSB:`PUMP_LSB];
      end
    end
  end

  // ****************************************
  // field outputs
  // ****************************************
  assign integer_value = feedback_divider_word_reg[`INT_MSB:`INT_LSB];
  assign numerator_value = feedback_divider_word_reg[`NUM_MSB:`NUM_LSB];
  // buffered copies: raw latch bits reach these pins only through a commit
  assign denominator_value = den_active_reg;
  assign phase_word = phase_active_reg;
  // prescaler and phase adjust are not buffered and act at once
  assign prescaler_select = phase_and_denominator_word_reg[`PRESC_BIT];
  assign phase_adjust_bit = phase_and_denominator_word_reg[`PH_ADJ_BIT];

  // ****************************************
  // reference path fields
  // ****************************************
  assign noise_mode = reference_and_pump_control_reg[`NOISE_MSB:`NOISE_LSB];
  assign output_mux_select = reference_and_pump_control_reg[`MUX_MSB:`MUX_LSB];
  assign reference_doubler = doubler_active_reg;
  assign reference_halving = halving_active_reg;
  assign reference_divider = rdiv_active_reg;
  assign pump_current = pump_active_reg;
  assign control_flags = reference_and_pump_control_reg[`FLAGS_MSB:`FLAGS_LSB];

  // ****************************************
  // clock divider, reserved and lock fields
  // ****************************************
  assign antibacklash_width = clock_divider_and_pfd_options_reg[`ABW_BIT];
  assign charge_cancel = clock_divider_and_pfd_options_reg[`CANCEL_BIT];
  assign cycle_slip_reduction = clock_divider_and_pfd_options_reg[`CSR_BIT];
  assign clock_divider_mode = clock_divider_and_pfd_options_reg[`CDM_MSB:`CDM_LSB];
  assign clock_divider_value = clock_divider_and_pfd_options_reg[`CDV_MSB:`CDV_LSB];
  // stored as written; checking the fixed pattern is left to the host
  assign reserved_pattern = reserved_fixed_pattern_reg[31:3];
  assign lock_pin_mode = lock_pin_configuration_reg[`LOCK_MSB:`LOCK_LSB];

  // ****************************************
  // strobes
  // ****************************************
  // single-cycle pulses; a watcher must sample every clk to see them
  assign commit_pulse = commit_reg;
  assign phase_resync_pulse = resync_reg;

endmodule // pll_synth_program_registers

`default_nettype wire

/* File: src/serial_word_receiver.v */
// three-wire serial receiver: pin synchronisers, msb-first shifter, latch strobe pulse
`default_nettype none

module serial_word_receiver (
  input wire clk,
  input wire arst_n,
  input wire serial_clk,
  input wire serial_data,
  input wire latch_strobe,
  output wire word_valid,
  output wire [31:0] word_data
);

  `include "pll_synth_defines.vh"

  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg sclk_prev_reg;
  reg strobe_prev_reg;
  reg [`WORD_WIDTH-1:0] shift_reg;
  reg [`WORD_WIDTH-1:0] word_reg;
  reg valid_reg;

  // first stage is read only by the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {latch_strobe, serial_data, serial_clk};
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // shifter and transfer strobe
  // ****************************************
  // data travels the same two stages as the clock, so it lines up at the edge
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_reg <= 1'b0;
      strobe_prev_reg <= 1'b0;
      shift_reg <= `LATCH_RESET;
      word_reg <= `LATCH_RESET;
      valid_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sync2_reg[0];
      strobe_prev_reg <= sync2_reg[2];
      if (sync2_reg[0] && !sclk_prev_reg) begin
        shift_reg <= {shift_reg[`WORD_WIDTH-2:0], sync2_reg[1]};
      end
      valid_reg <= sync2_reg[2] && !strobe_prev_reg;
      if (sync2_reg[2] && !strobe_prev_reg) begin
        word_reg <= shift_reg;
      end
    end
  end

  assign word_valid = valid_reg;
  assign word_data = word_reg;

endmodule // serial_word_receiver

`default_nettype wire
